// >>> logic/ccf_pkg.sv
// Package for the condition-code flag block: bit positions, opcodes, carrier structs.
// Assumes a single core clock domain; shared by the design files of the block except the mask gate.
`default_nettype none
package ccf_pkg;

   // Flag register bit positions
   localparam int unsigned BIT_MASK  = 7;
   localparam int unsigned BIT_USR_H = 6;
   localparam int unsigned BIT_HALF  = 5;
   localparam int unsigned BIT_USR_L = 4;
   localparam int unsigned BIT_NEG   = 3;
   localparam int unsigned BIT_ZERO  = 2;
   localparam int unsigned BIT_OVF   = 1;
   localparam int unsigned BIT_CARRY = 0;

   // Half-carry tap positions per operand size
   localparam int unsigned HC_BYTE = 3;
   localparam int unsigned HC_WORD = 11;
   localparam int unsigned HC_LONG = 27;

   // Width of operands and result data
   localparam int unsigned DATA_W = 32;

   // Reset value: mask bit set, the rest cleared for determinism
   localparam logic [7:0] FLAGS_RESET = 8'h80;

   typedef enum logic [1:0] {
      CCF_SZ_BYTE = 2'b00,
      CCF_SZ_WORD = 2'b01,
      CCF_SZ_LONG = 2'b10
   } ccf_size_type;

   typedef enum logic [3:0] {
      CCF_OP_NONE  = 4'b0000,
      CCF_OP_ADD   = 4'b0001,
      CCF_OP_ADDX  = 4'b0010,
      CCF_OP_SUB   = 4'b0011,
      CCF_OP_SUBX  = 4'b0100,
      CCF_OP_CMP   = 4'b0101,
      CCF_OP_NEG   = 4'b0110,
      CCF_OP_LOGIC = 4'b0111,
      CCF_OP_SHIFT = 4'b1000,
      CCF_OP_BITLD = 4'b1001,
      CCF_OP_BITAND= 4'b1010,
      CCF_OP_BITOR = 4'b1011,
      CCF_OP_BITXOR= 4'b1100
   } ccf_op_type;

   typedef enum logic [2:0] {
      CCF_CR_NONE  = 3'b000,
      CCF_CR_LOAD  = 3'b001,
      CCF_CR_AND   = 3'b010,
      CCF_CR_OR    = 3'b011,
      CCF_CR_XOR   = 3'b100
   } ccf_crop_type;

   // Arithmetic request from the ALU
   typedef struct packed {
      logic                valid;
      ccf_op_type          op;
      ccf_size_type        size;
      logic [DATA_W-1:0]   opa;
      logic [DATA_W-1:0]   opb;
      logic                shift_out;
      logic                bit_in;
      logic                bit_inv;
   } ccf_alu_req_type;

   // Flag results computed from one request
   typedef struct packed {
      logic                half;
      logic                neg;
      logic                zero;
      logic                ovf;
      logic                carry;
      logic [DATA_W-1:0]   result;
   } ccf_flag_res_type;

endpackage : ccf_pkg
`default_nettype wire

// >>> logic/ccf_arith.sv
// Combinational flag evaluator: computes result and H/N/Z/V/C for one ALU request.
// Assumes operands are right-aligned; higher bits outside the size are ignored.
`timescale 1ns/1ps
`default_nettype none
module ccf_arith (
   input  wire ccf_pkg::ccf_alu_req_type  req,
   output ccf_pkg::ccf_flag_res_type      res,
   output logic                           carry_x_in_use
);
   localparam int unsigned W = ccf_pkg::DATA_W;

   logic          is_sub;
   logic          use_x;
   logic          cin;
   logic [W-1:0]  a_sel;
   logic [W-1:0]  b_sel;
   logic [W:0]    sum;
   logic [W-1:0]  cvec;
   logic [W-1:0]  rmask;
   logic [W-1:0]  r_m;
   logic          msb_r;
   logic          msb_a;
   logic          msb_b;
   logic          cout;

   // Carry input for extend forms comes in through bit_in
   assign use_x  = (req.op == ccf_pkg::CCF_OP_ADDX) || (req.op == ccf_pkg::CCF_OP_SUBX);
   assign carry_x_in_use = use_x;
   assign is_sub = (req.op == ccf_pkg::CCF_OP_SUB) || (req.op == ccf_pkg::CCF_OP_SUBX)
                || (req.op == ccf_pkg::CCF_OP_CMP) || (req.op == ccf_pkg::CCF_OP_NEG);
   // Negate is zero minus the operand
   assign a_sel  = (req.op == ccf_pkg::CCF_OP_NEG) ? '0 : req.opa;
   assign b_sel  = is_sub ? ~req.opb : req.opb;
   assign cin    = is_sub ? ~(use_x & req.bit_in) : (use_x & req.bit_in);
   assign sum    = {1'b0, a_sel} + {1'b0, b_sel} + {{W{1'b0}}, cin};
   // Carry into each bit position: a ^ b ^ sum
   assign cvec   = a_sel ^ b_sel ^ sum[W-1:0];

   assign rmask  = (req.size == ccf_pkg::CCF_SZ_BYTE) ? 32'h0000_00ff :
                   (req.size == ccf_pkg::CCF_SZ_WORD) ? 32'h0000_ffff : 32'hffff_ffff;
   assign r_m    = ((req.op == ccf_pkg::CCF_OP_LOGIC) || (req.op == ccf_pkg::CCF_OP_SHIFT))
                   ? (req.opa & rmask) : (sum[W-1:0] & rmask);
   assign msb_r  = (req.size == ccf_pkg::CCF_SZ_BYTE) ? r_m[7] :
                   (req.size == ccf_pkg::CCF_SZ_WORD) ? r_m[15] : r_m[31];
   assign msb_a  = (req.size == ccf_pkg::CCF_SZ_BYTE) ? a_sel[7] :
                   (req.size == ccf_pkg::CCF_SZ_WORD) ? a_sel[15] : a_sel[31];
   assign msb_b  = (req.size == ccf_pkg::CCF_SZ_BYTE) ? b_sel[7] :
                   (req.size == ccf_pkg::CCF_SZ_WORD) ? b_sel[15] : b_sel[31];
   assign cout   = (req.size == ccf_pkg::CCF_SZ_BYTE) ? cvec[8] :
                   (req.size == ccf_pkg::CCF_SZ_WORD) ? cvec[16] : sum[W];

   always_comb begin
      res.result = r_m;
      // RL7: sign from msb
      res.neg    = msb_r;
      // RL8: zero detect
      res.zero   = (r_m == '0);
      // RL9: signed overflow
      res.ovf    = (msb_a == msb_b) && (msb_r != msb_a);
      // RL4 RL5 RL6: half-carry tap; inverted for borrow
      unique case (req.size)
         ccf_pkg::CCF_SZ_BYTE: res.half = cvec[ccf_pkg::HC_BYTE + 1] ^ is_sub;
         ccf_pkg::CCF_SZ_WORD: res.half = cvec[ccf_pkg::HC_WORD + 1] ^ is_sub;
         default:              res.half = cvec[ccf_pkg::HC_LONG + 1] ^ is_sub;
      endcase
      // RL10: carry or borrow, shift-out for shifts
      res.carry  = (req.op == ccf_pkg::CCF_OP_SHIFT) ? req.shift_out : (cout ^ is_sub);
   end
endmodule : ccf_arith
`default_nettype wire

// >>> logic/ccf_mask_gate.sv
// Interrupt acceptance gate driven by the mask bit of the flag register.
// Assumes interrupt requests are synchronous levels from the interrupt controller.
`timescale 1ns/1ps
`default_nettype none
module ccf_mask_gate (
   input  wire logic  mask_bit,
   input  wire logic  irq_req,
   input  wire logic  nmi_req,
   output logic       irq_accept,
   output logic       nmi_accept
);
   // RL1: mask blocks all but NMI
   assign irq_accept = irq_req & ~mask_bit;
   assign nmi_accept = nmi_req;
endmodule : ccf_mask_gate
`default_nettype wire

// >>> logic/ccf_flags.sv
// Condition-code flag register of the core, updated by ALU, exceptions and control ops.
// Assumes one request source per cycle is intended; priority resolves collisions.
//
// Contract
// RL1: While the mask bit is 1 only the non-maskable interrupt is accepted.
// RL2: Starting an exception sequence forces the mask bit to 1.
// RL3: The two user bits have no hardware effect and are read and written by control ops.
// RL4: Byte add/addx/sub/subx/cmp/neg set half-carry from carry or borrow at bit 3.
// RL5: Word add/sub/cmp/neg set half-carry from carry or borrow at bit 11.
// RL6: Long add/sub/cmp/neg set half-carry from carry or borrow at bit 27.
// RL7: The negative flag takes the most significant result bit.
// RL8: The zero flag is 1 for a zero result and 0 otherwise; extend forms here only clear it and never set it.
// RL9: The overflow flag is 1 on signed overflow and 0 otherwise.
// RL10: Carry reports add carry, subtract borrow, or the bit shifted out.
// RL11: Bit operations use carry as a one-bit accumulator.
// RL12: Flags an operation does not define keep their value; control writes override.
`timescale 1ns/1ps
`default_nettype none
module ccf_flags (
   input  wire logic                      sys_clk,
   input  wire logic                      reset_n,
   input  wire ccf_pkg::ccf_alu_req_type  alu_req,
   input  wire logic                      exc_start,
   input  wire ccf_pkg::ccf_crop_type     cr_op,
   input  wire logic [7:0]                cr_data,
   input  wire logic                      irq_req,
   input  wire logic                      nmi_req,
   output logic [7:0]                     flags,
   output logic                           irq_accept,
   output logic                           nmi_accept
);
   logic [7:0]                 flags_q;
   logic [7:0]                 flags_d;
   logic [7:0]                 alu_flags;
   logic [7:0]                 cr_flags;
   ccf_pkg::ccf_flag_res_type  res;
   logic                       arith_op;
   logic                       h_op;
   logic                       logic_op;
   logic                       shift_op;
   logic                       bit_op;
   logic                       bit_val;
   logic                       c_acc;
   logic                       alu_go;
   logic                       cr_go;
   logic                       addx_sel;

   ccf_arith ccf_arith_inst (
      .req            (alu_req),
      .res            (res),
      .carry_x_in_use (addx_sel)
   );

   ccf_mask_gate ccf_mask_gate_inst (
      .mask_bit   (flags_q[ccf_pkg::BIT_MASK]),
      .irq_req    (irq_req),
      .nmi_req    (nmi_req),
      .irq_accept (irq_accept),
      .nmi_accept (nmi_accept)
   );

   assign alu_go   = alu_req.valid && (alu_req.op != ccf_pkg::CCF_OP_NONE);
   assign cr_go    = (cr_op != ccf_pkg::CCF_CR_NONE);
   assign h_op     = (alu_req.op == ccf_pkg::CCF_OP_ADD)  || (alu_req.op == ccf_pkg::CCF_OP_SUB)
                  || (alu_req.op == ccf_pkg::CCF_OP_CMP)  || (alu_req.op == ccf_pkg::CCF_OP_NEG)
                  || (((alu_req.op == ccf_pkg::CCF_OP_ADDX) || (alu_req.op == ccf_pkg::CCF_OP_SUBX))
                      && (alu_req.size == ccf_pkg::CCF_SZ_BYTE));
   assign arith_op = h_op || addx_sel;
   assign logic_op = (alu_req.op == ccf_pkg::CCF_OP_LOGIC);
   assign shift_op = (alu_req.op == ccf_pkg::CCF_OP_SHIFT);
   assign bit_op   = (alu_req.op == ccf_pkg::CCF_OP_BITLD) || (alu_req.op == ccf_pkg::CCF_OP_BITAND)
                  || (alu_req.op == ccf_pkg::CCF_OP_BITOR) || (alu_req.op == ccf_pkg::CCF_OP_BITXOR);
   assign bit_val  = alu_req.bit_in ^ alu_req.bit_inv;

   // RL11: carry as bit accumulator
   always_comb begin
      c_acc = flags_q[ccf_pkg::BIT_CARRY];
      unique case (alu_req.op)
         ccf_pkg::CCF_OP_BITLD:  c_acc = bit_val;
         ccf_pkg::CCF_OP_BITAND: c_acc = flags_q[ccf_pkg::BIT_CARRY] & bit_val;
         ccf_pkg::CCF_OP_BITOR:  c_acc = flags_q[ccf_pkg::BIT_CARRY] | bit_val;
         ccf_pkg::CCF_OP_BITXOR: c_acc = flags_q[ccf_pkg::BIT_CARRY] ^ bit_val;
         default:                c_acc = flags_q[ccf_pkg::BIT_CARRY];
      endcase
   end

   // RL12: untouched flags hold
   always_comb begin
      alu_flags = flags_q;
      if (arith_op) begin
         // RL4 RL5 RL6: half-carry only for listed ops
         if (h_op) begin
            alu_flags[ccf_pkg::BIT_HALF] = res.half;
         end
         alu_flags[ccf_pkg::BIT_NEG]   = res.neg;
         // RL8: extend forms only clear zero, keeping multi-precision zero
         alu_flags[ccf_pkg::BIT_ZERO]  = addx_sel ? (res.zero & flags_q[ccf_pkg::BIT_ZERO])
                                                  : res.zero;
         alu_flags[ccf_pkg::BIT_OVF]   = res.ovf;
         alu_flags[ccf_pkg::BIT_CARRY] = res.carry;
      end else if (logic_op || shift_op) begin
         alu_flags[ccf_pkg::BIT_NEG]   = res.neg;
         alu_flags[ccf_pkg::BIT_ZERO]  = res.zero;
         alu_flags[ccf_pkg::BIT_OVF]   = 1'b0;
         if (shift_op) begin
            alu_flags[ccf_pkg::BIT_CARRY] = res.carry;
         end
      end else if (bit_op) begin
         alu_flags[ccf_pkg::BIT_CARRY] = c_acc;
      end
   end

   // RL3: control ops reach every bit, user bits included
   always_comb begin
      cr_flags = flags_q;
      unique case (cr_op)
         ccf_pkg::CCF_CR_LOAD: cr_flags = cr_data;
         ccf_pkg::CCF_CR_AND:  cr_flags = flags_q & cr_data;
         ccf_pkg::CCF_CR_OR:   cr_flags = flags_q | cr_data;
         ccf_pkg::CCF_CR_XOR:  cr_flags = flags_q ^ cr_data;
         default:              cr_flags = flags_q;
      endcase
   end

   // Control writes override ALU results; exception start wins on the mask
   always_comb begin
      flags_d = cr_go ? cr_flags : (alu_go ? alu_flags : flags_q);
      // RL2: exception forces mask
      if (exc_start) begin
         flags_d[ccf_pkg::BIT_MASK] = 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         flags_q <= ccf_pkg::FLAGS_RESET;
      end else begin
         flags_q <= flags_d;
      end
   end

   assign flags = flags_q;

   // RL2: mask set after exception
   property p_exc_mask;
      @(posedge sys_clk) disable iff (!reset_n)
      exc_start |=> flags_q[ccf_pkg::BIT_MASK];
   endproperty
   a_exc_mask: assert property (p_exc_mask) else $error("mask not set by exception"); // RL2

   // RL1: masked irq never accepted
   property p_irq_block;
      @(posedge sys_clk) disable iff (!reset_n)
      flags_q[ccf_pkg::BIT_MASK] |-> !irq_accept && (nmi_accept == nmi_req);
   endproperty
   a_irq_block: assert property (p_irq_block) else $error("irq passed mask"); // RL1

   // RL8: zero flag follows result
   property p_zero;
      @(posedge sys_clk) disable iff (!reset_n)
      (alu_go && !cr_go && !addx_sel && (arith_op || logic_op || shift_op))
      |=> (flags_q[ccf_pkg::BIT_ZERO] == $past(res.zero));
   endproperty
   a_zero: assert property (p_zero) else $error("zero flag wrong"); // RL8

   // RL7: negative flag follows sign
   property p_neg;
      @(posedge sys_clk) disable iff (!reset_n)
      (alu_go && !cr_go && (arith_op || logic_op || shift_op))
      |=> (flags_q[ccf_pkg::BIT_NEG] == $past(res.neg));
   endproperty
   a_neg: assert property (p_neg) else $error("negative flag wrong"); // RL7

   // RL4: byte add half-carry at bit 3
   property p_half_byte;
      @(posedge sys_clk) disable iff (!reset_n)
      (alu_go && !cr_go && (alu_req.op == ccf_pkg::CCF_OP_ADD)
       && (alu_req.size == ccf_pkg::CCF_SZ_BYTE))
      |=> (flags_q[ccf_pkg::BIT_HALF]
           == $past((({1'b0, alu_req.opa[3:0]} + {1'b0, alu_req.opb[3:0]}) >> 4) != 5'h00));
   endproperty
   a_half_byte: assert property (p_half_byte) else $error("byte half-carry wrong"); // RL4

   // RL10: add carry out of byte
   property p_carry_add;
      @(posedge sys_clk) disable iff (!reset_n)
      (alu_go && !cr_go && (alu_req.op == ccf_pkg::CCF_OP_ADD)
       && (alu_req.size == ccf_pkg::CCF_SZ_BYTE))
      |=> (flags_q[ccf_pkg::BIT_CARRY]
           == $past((({1'b0, alu_req.opa[7:0]} + {1'b0, alu_req.opb[7:0]}) >> 8) != 9'h000));
   endproperty
   a_carry_add: assert property (p_carry_add) else $error("add carry wrong"); // RL10

   // RL11: bit load into carry
   property p_bitld;
      @(posedge sys_clk) disable iff (!reset_n)
      (alu_go && !cr_go && (alu_req.op == ccf_pkg::CCF_OP_BITLD))
      |=> (flags_q[ccf_pkg::BIT_CARRY] == $past(alu_req.bit_in ^ alu_req.bit_inv));
   endproperty
   a_bitld: assert property (p_bitld) else $error("bit load to carry wrong"); // RL11

   // RL12: idle cycle holds all flags
   property p_hold;
      @(posedge sys_clk) disable iff (!reset_n)
      (!alu_go && !cr_go && !exc_start) |=> $stable(flags_q);
   endproperty
   a_hold: assert property (p_hold) else $error("flags changed while idle"); // RL12

   // RL3: load writes user bits
   property p_user_load;
      @(posedge sys_clk) disable iff (!reset_n)
      (cr_op == ccf_pkg::CCF_CR_LOAD)
      |=> (flags_q[ccf_pkg::BIT_USR_H] == $past(cr_data[ccf_pkg::BIT_USR_H]))
          && (flags_q[ccf_pkg::BIT_USR_L] == $past(cr_data[ccf_pkg::BIT_USR_L]));
   endproperty
   a_user_load: assert property (p_user_load) else $error("user bits not loaded"); // RL3

   // RL9: byte add overflow
   property p_ovf;
      @(posedge sys_clk) disable iff (!reset_n)
      (alu_go && !cr_go && (alu_req.op == ccf_pkg::CCF_OP_ADD)
       && (alu_req.size == ccf_pkg::CCF_SZ_BYTE))
      |=> (flags_q[ccf_pkg::BIT_OVF] == $past((alu_req.opa[7] == alu_req.opb[7])
           && (res.result[7] != alu_req.opa[7])));
   endproperty
   a_ovf: assert property (p_ovf) else $error("overflow flag wrong"); // RL9

   // RL5: word add half-carry at bit 11
   property p_half_word;
      @(posedge sys_clk) disable iff (!reset_n)
      (alu_go && !cr_go && (alu_req.op == ccf_pkg::CCF_OP_ADD)
       && (alu_req.size == ccf_pkg::CCF_SZ_WORD))
      |=> (flags_q[ccf_pkg::BIT_HALF]
           == $past(((({1'b0, alu_req.opa[ccf_pkg::HC_WORD:0]}
                      + {1'b0, alu_req.opb[ccf_pkg::HC_WORD:0]})
                     >> (ccf_pkg::HC_WORD + 1)) != '0)));
   endproperty
   a_half_word: assert property (p_half_word) else $error("word half-carry wrong"); // RL5

   // RL6: long add half-carry at bit 27
   property p_half_long;
      @(posedge sys_clk) disable iff (!reset_n)
      (alu_go && !cr_go && (alu_req.op == ccf_pkg::CCF_OP_ADD)
       && (alu_req.size == ccf_pkg::CCF_SZ_LONG))
      |=> (flags_q[ccf_pkg::BIT_HALF]
           == $past(((({1'b0, alu_req.opa[ccf_pkg::HC_LONG:0]}
                      + {1'b0, alu_req.opb[ccf_pkg::HC_LONG:0]})
                     >> (ccf_pkg::HC_LONG + 1)) != '0)));
   endproperty
   a_half_long: assert property (p_half_long) else $error("long half-carry wrong"); // RL6

   // RL4: byte subtract borrow at bit 3
   property p_half_sub;
      @(posedge sys_clk) disable iff (!reset_n)
      (alu_go && !cr_go && (alu_req.op == ccf_pkg::CCF_OP_SUB)
       && (alu_req.size == ccf_pkg::CCF_SZ_BYTE))
      |=> (flags_q[ccf_pkg::BIT_HALF]
           == $past(alu_req.opa[ccf_pkg::HC_BYTE:0] < alu_req.opb[ccf_pkg::HC_BYTE:0]));
   endproperty
   a_half_sub: assert property (p_half_sub) else $error("byte borrow half-carry wrong"); // RL4

   // RL10: byte subtract reports borrow
   property p_carry_sub;
      @(posedge sys_clk) disable iff (!reset_n)
      (alu_go && !cr_go && (alu_req.op == ccf_pkg::CCF_OP_SUB)
       && (alu_req.size == ccf_pkg::CCF_SZ_BYTE))
      |=> (flags_q[ccf_pkg::BIT_CARRY]
           == $past(alu_req.opa[7:0] < alu_req.opb[7:0]));
   endproperty
   a_carry_sub: assert property (p_carry_sub) else $error("subtract borrow wrong"); // RL10

   // RL10: shift reports bit shifted out
   property p_carry_shift;
      @(posedge sys_clk) disable iff (!reset_n)
      (alu_go && !cr_go && shift_op)
      |=> (flags_q[ccf_pkg::BIT_CARRY] == $past(alu_req.shift_out));
   endproperty
   a_carry_shift: assert property (p_carry_shift) else $error("shift carry wrong"); // RL10

   // RL9: no overflow from logic or shift
   property p_ovf_clear;
      @(posedge sys_clk) disable iff (!reset_n)
      (alu_go && !cr_go && (logic_op || shift_op)) |=> !flags_q[ccf_pkg::BIT_OVF];
   endproperty
   a_ovf_clear: assert property (p_ovf_clear) else $error("overflow left set"); // RL9

   // RL11: bit and into carry
   property p_bitand;
      @(posedge sys_clk) disable iff (!reset_n)
      (alu_go && !cr_go && (alu_req.op == ccf_pkg::CCF_OP_BITAND))
      |=> (flags_q[ccf_pkg::BIT_CARRY]
           == $past(flags_q[ccf_pkg::BIT_CARRY] & (alu_req.bit_in ^ alu_req.bit_inv)));
   endproperty
   a_bitand: assert property (p_bitand) else $error("bit and into carry wrong"); // RL11

   // RL12: control load overrides every flag
   property p_cr_load;
      @(posedge sys_clk) disable iff (!reset_n)
      ((cr_op == ccf_pkg::CCF_CR_LOAD) && !exc_start)
      |=> (flags_q == $past(cr_data));
   endproperty
   a_cr_load: assert property (p_cr_load) else $error("control load not applied"); // RL12

   // RL1: open mask passes the request through
   property p_irq_open;
      @(posedge sys_clk) disable iff (!reset_n)
      !flags_q[ccf_pkg::BIT_MASK] |-> (irq_accept == irq_req);
   endproperty
   a_irq_open: assert property (p_irq_open) else $error("irq blocked while unmasked"); // RL1

   // RL3: only control ops change user bits
   property p_user_keep;
      @(posedge sys_clk) disable iff (!reset_n)
      !cr_go |=> ($stable(flags_q[ccf_pkg::BIT_USR_H])
                  && $stable(flags_q[ccf_pkg::BIT_USR_L]));
   endproperty
   a_user_keep: assert property (p_user_keep) else $error("user bits changed"); // RL3

endmodule : ccf_flags
`default_nettype wire

// >>> tb/ccf_core_model.sv
// Partner model: arithmetic unit and exception sequencer feeding the flag register.
// Assumes the bench calls its tasks from one process; requests launch just after rising edges.
`timescale 1ns/1ps
`default_nettype none
module ccf_core_model (
   input  wire logic                     sys_clk,
   input  wire logic [7:0]               flags,
   output var  ccf_pkg::ccf_alu_req_type alu_req,
   output var  logic                     exc_start
);
   initial begin
      alu_req   = '0;
      exc_start = 1'b0;
   end

   task automatic issue(input ccf_pkg::ccf_op_type op, input ccf_pkg::ccf_size_type sz,
         input logic [31:0] a, input logic [31:0] b, input logic sh, input logic bi,
         input logic bv);
      ccf_pkg::ccf_alu_req_type r;
      r.valid     = 1'b1;
      r.op        = op;
      r.size      = sz;
      r.opa       = a;
      r.opb       = b;
      r.shift_out = sh;
      r.bit_inv   = bv;
      // carry chained in
      // Extend ops take the live carry, so a stale bench value cannot leak in
      r.bit_in    = (op == ccf_pkg::CCF_OP_ADDX || op == ccf_pkg::CCF_OP_SUBX) ? flags[0] : bi;
      @(posedge sys_clk);
      alu_req <= r;
      @(posedge sys_clk);
      alu_req <= '0;
   endtask : issue

   task automatic exception();
      @(posedge sys_clk);
      exc_start <= 1'b1;
      @(posedge sys_clk);
      exc_start <= 1'b0;
   endtask : exception
endmodule : ccf_core_model
`default_nettype wire

// >>> tb/ccf_flags_test.sv
// Self-checking bench for the condition-code flag register.
// Assumes the partner model drives the ALU and exception side; flags land one edge later.
`timescale 1ns/1ps
`default_nettype none
module ccf_flags_test;
   logic                     sys_clk;
   logic                     reset_n;
   logic                     irq_req;
   logic                     nmi_req;
   logic                     exc_start;
   logic                     irq_accept;
   logic                     nmi_accept;
   logic [7:0]               cr_data;
   logic [7:0]               flags;
   ccf_pkg::ccf_crop_type    cr_op;
   ccf_pkg::ccf_alu_req_type alu_req;
   int                       err_total;
   int                       checks;

   ccf_flags ccf_flags_inst (
      .sys_clk    (sys_clk),
      .reset_n    (reset_n),
      .alu_req    (alu_req),
      .exc_start  (exc_start),
      .cr_op      (cr_op),
      .cr_data    (cr_data),
      .irq_req    (irq_req),
      .nmi_req    (nmi_req),
      .flags      (flags),
      .irq_accept (irq_accept),
      .nmi_accept (nmi_accept)
   );

   ccf_core_model ccf_core_model_inst (
      .sys_clk   (sys_clk),
      .flags     (flags),
      .alu_req   (alu_req),
      .exc_start (exc_start)
   );

   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic results();
      $display("mismatches %0d comparisons %0d", err_total, checks);
      if (err_total == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : results

   task automatic cr(input ccf_pkg::ccf_crop_type op, input logic [7:0] d);
      @(posedge sys_clk);
      cr_op   <= op;
      cr_data <= d;
      @(posedge sys_clk);
      cr_op   <= ccf_pkg::CCF_CR_NONE;
      #1;
   endtask : cr

   // Preload the flags so untouched bits show whether they were kept
   task automatic alu(input logic [7:0] base, input ccf_pkg::ccf_op_type op,
         input ccf_pkg::ccf_size_type sz, input logic [31:0] a, input logic [31:0] b,
         input logic [2:0] sbv, input logic [7:0] exp);
      cr(ccf_pkg::CCF_CR_LOAD, base);
      ccf_core_model_inst.issue(op, sz, a, b, sbv[2], sbv[1], sbv[0]);
      #1;
      chk(flags, exp);
   endtask : alu

   initial begin
      repeat (5000) @(posedge sys_clk);
      err_total++;
      results();
   end

   initial begin
      err_total = 0;
      checks    = 0;
      reset_n   = 1'b0;
      irq_req   = 1'b1;
      nmi_req   = 1'b1;
      cr_op     = ccf_pkg::CCF_CR_NONE;
      cr_data   = 8'h00;
      repeat (4) @(posedge sys_clk);
      reset_n <= 1'b1;
      #1;
      chk(flags, 8'h80);
      chk({7'h00, irq_accept}, 8'h00);
      chk({7'h00, nmi_accept}, 8'h01);
      cr(ccf_pkg::CCF_CR_LOAD, 8'h50);
      chk(flags, 8'h50);
      chk({7'h00, irq_accept}, 8'h01);
      cr(ccf_pkg::CCF_CR_AND, 8'h40);
      chk(flags, 8'h40);
      cr(ccf_pkg::CCF_CR_OR, 8'h10);
      chk(flags, 8'h50);
      cr(ccf_pkg::CCF_CR_XOR, 8'hff);
      chk(flags, 8'haf);
      alu(8'h50, ccf_pkg::CCF_OP_ADD, ccf_pkg::CCF_SZ_BYTE, 32'hff0f, 32'h1, 3'h0, 8'h70);
      alu(8'h50, ccf_pkg::CCF_OP_ADD, ccf_pkg::CCF_SZ_BYTE, 32'h7f, 32'h1, 3'h0, 8'h7a);
      alu(8'h50, ccf_pkg::CCF_OP_ADD, ccf_pkg::CCF_SZ_BYTE, 32'hff, 32'h1, 3'h0, 8'h75);
      alu(8'h50, ccf_pkg::CCF_OP_SUB, ccf_pkg::CCF_SZ_BYTE, 32'h0, 32'h1, 3'h0, 8'h79);
      alu(8'h50, ccf_pkg::CCF_OP_CMP, ccf_pkg::CCF_SZ_BYTE, 32'h10, 32'h1, 3'h0, 8'h70);
      alu(8'h50, ccf_pkg::CCF_OP_NEG, ccf_pkg::CCF_SZ_BYTE, 32'h0, 32'h80, 3'h0, 8'h5b);
      alu(8'h51, ccf_pkg::CCF_OP_ADDX, ccf_pkg::CCF_SZ_BYTE, 32'h0e, 32'h1, 3'h0, 8'h70);
      alu(8'h55, ccf_pkg::CCF_OP_SUBX, ccf_pkg::CCF_SZ_BYTE, 32'h1, 32'h0, 3'h0, 8'h54);
      alu(8'h50, ccf_pkg::CCF_OP_ADD, ccf_pkg::CCF_SZ_WORD, 32'h800, 32'h800, 3'h0, 8'h70);
      alu(8'h50, ccf_pkg::CCF_OP_SUB, ccf_pkg::CCF_SZ_WORD, 32'h1000, 32'h1, 3'h0, 8'h70);
      alu(8'h50, ccf_pkg::CCF_OP_ADD, ccf_pkg::CCF_SZ_LONG, 32'h7fffffff, 32'h1, 3'h0, 8'h7a);
      alu(8'h50, ccf_pkg::CCF_OP_SUB, ccf_pkg::CCF_SZ_LONG, 32'h0, 32'h1, 3'h0, 8'h79);
      alu(8'h70, ccf_pkg::CCF_OP_SHIFT, ccf_pkg::CCF_SZ_BYTE, 32'h0, 32'h0, 3'h4, 8'h75);
      alu(8'h51, ccf_pkg::CCF_OP_LOGIC, ccf_pkg::CCF_SZ_BYTE, 32'h80, 32'h0, 3'h0, 8'h59);
      alu(8'h50, ccf_pkg::CCF_OP_BITLD, ccf_pkg::CCF_SZ_BYTE, 32'h0, 32'h0, 3'h2, 8'h51);
      alu(8'h51, ccf_pkg::CCF_OP_BITAND, ccf_pkg::CCF_SZ_BYTE, 32'h0, 32'h0, 3'h0, 8'h50);
      alu(8'h50, ccf_pkg::CCF_OP_BITOR, ccf_pkg::CCF_SZ_BYTE, 32'h0, 32'h0, 3'h1, 8'h51);
      alu(8'h51, ccf_pkg::CCF_OP_BITXOR, ccf_pkg::CCF_SZ_BYTE, 32'h0, 32'h0, 3'h2, 8'h50);
      // Control write and ALU result in the same cycle: the write must win
      fork
         cr(ccf_pkg::CCF_CR_LOAD, 8'h00);
         ccf_core_model_inst.issue(ccf_pkg::CCF_OP_ADD, ccf_pkg::CCF_SZ_BYTE, 32'hff, 32'h1,
            1'b0, 1'b0, 1'b0);
      join
      #1;
      chk(flags, 8'h00);
      chk({7'h00, irq_accept}, 8'h01);
      // Drop both requests so the gate outputs are seen following them low too
      @(posedge sys_clk);
      irq_req <= 1'b0;
      nmi_req <= 1'b0;
      #1;
      chk({7'h00, irq_accept}, 8'h00);
      chk({7'h00, nmi_accept}, 8'h00);
      @(posedge sys_clk);
      irq_req <= 1'b1;
      nmi_req <= 1'b1;
      #1;
      chk({7'h00, irq_accept}, 8'h01);
      fork
         cr(ccf_pkg::CCF_CR_LOAD, 8'h40);
         ccf_core_model_inst.exception();
      join
      #1;
      chk(flags, 8'hc0);
      chk({7'h00, irq_accept}, 8'h00);
      chk({7'h00, nmi_accept}, 8'h01);
      results();
   end
endmodule : ccf_flags_test
`default_nettype wire
